//--- src/edc_pkg.sv
// Package of constants shared by both ends of the event delay counter link
package edc_pkg;
  localparam int unsigned CNT_W = 35;
  localparam int unsigned BYTES = 5;
  localparam logic [15:0] STEP_ADDR = 16'h4884;
  localparam logic [7:0] TRIG_FREE_RUN = 8'h03;
  localparam logic [7:0] PRESCALE_INIT = 8'hF2;
  localparam logic [3:0] SUB_MAX = 4'hF;
  localparam logic [CNT_W-1:0] CNT_RESET = 35'h0_0000_FFFF;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_DATA_LO = 32'h0000_0004;
  localparam logic [31:0] OFS_DATA_HI = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS = 32'h0000_000C;
  localparam logic [31:0] OFS_CMD = 32'h0000_0010;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_TC = 3'h5;
  localparam logic [2:0] ADDR_TRIG = 3'h6;
  localparam logic [2:0] ADDR_PRESCALE = 3'h7;
endpackage

//--- src/edc_if.sv
// Interface joining the processor end and the counter end
`timescale 1ns/100ps
interface edc_if;
  logic wr;
  logic rd;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [15:0] step_addr;
  logic step_access;
  logic load_strobe;
  logic clock_source_select;
  logic alt_clock_enable_n;
  logic alt_clock_step_bit;
  logic event_clk;
  modport dev (input wr, input rd, input addr, input wdata, output rdata, input step_addr, input step_access,
    input load_strobe, input clock_source_select, input alt_clock_enable_n, input alt_clock_step_bit,
    input event_clk);
  modport host (output wr, output rd, output addr, output wdata, input rdata, output step_addr,
    output step_access, output load_strobe, output clock_source_select, output alt_clock_enable_n,
    output alt_clock_step_bit, output event_clk);
endinterface

//--- src/edc_counter.sv
// Device end: 35-bit event delay down counter with load, terminal count and clock stepping
`timescale 1ns/100ps
// Operation
// R1: 35-bit down counter with load, terminal count
// R2: Host writes five bytes, low byte first
// R3: Host reads five bytes, masks top five bits
// R4: Readback returns inverted counter contents
// R5: At counted zero, read inverse of last load
// R6: Inverse of zero only after loading zero
// R7: Zero accepted as load value
// R8: Decrement by one per clock pulse
// R9: Terminal count readable after load or step
// R10: Reset load FFFF keeps terminal count low
// R11: Active-high load strobe, low blocks reload
// R12: Step access at 4884 gives one pulse
// R13: Host steps alt clock low then high
// R14: Source select high stops main clock
// R15: Alt clock off when select and bit high
// R16: Trigger register 03 means free run
// R17: Prescaler F2 enables path, sub-counter F
// R18: Host reports upper, middle, lower mismatches
// R19: After zero load, tc one, read inverse zero
// R20: Tc set at zero, cleared nonzero load
// R21: Reset holds control logic initial
module edc_counter (
  input wire logic hclk,
  input wire logic hresetn,
  edc_if.dev link,
  output logic terminal_count,
  output logic trigger_free_run,
  output logic event_path_enable,
  output logic sub_tc,
  output logic sys_clk_pulse,
  output logic [edc_pkg::CNT_W-1:0] count
);
  // Latches and counter are 35 bits wide; the latch byte view and the readback word pad to 40 so that
  // five whole bytes can be addressed without a special case for the last one.
  logic [edc_pkg::CNT_W-1:0] input_latch; // Staged load value
  logic [edc_pkg::CNT_W-1:0] last_load; // Last value copied in
  logic [39:0] latch_wide; // Byte-wide view of the latch
  logic [7:0] trig_reg; // Trigger shift register image
  logic [7:0] prescale_reg; // Prescaler register image
  logic [3:0] sub_count; // Prescaler sub-counter
  logic [2:0] alt_sync; // Pin synchroniser for alt step bit
  logic [2:0] ev_sync; // Pin synchroniser for event clock
  logic alt_prev; // Previous settled alt level
  logic ev_prev; // Previous settled event level
  logic alt_tick; // Alt clock rising edge
  logic ev_tick; // Event clock rising edge
  logic count_pulse; // One count or load step
  logic alt_free; // Free-running alternate path, modelled as one count per cycle
  logic [39:0] read_wide; // Readback word
  // The counter has one clock; every outside clock is seen as a level that is sampled and
  // edge-detected here, so a slow or hand-stepped source never clocks a flop directly.
  // The price is a few cycles of latency between a level change and the count it causes.

  // Synchronisers; a change counts once stages two and three agree
  // Reset values match each line's idle level (step bit high, event clock low), so the
  // release of reset never looks like a rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Idle levels
      alt_sync <= 3'h7;
      ev_sync <= 3'h0;
      alt_prev <= 1'b1;
      ev_prev <= 1'b0;
    end else begin
      // Shift in the raw levels
      alt_sync <= {alt_sync[1:0], link.alt_clock_step_bit};
      ev_sync <= {ev_sync[1:0], link.event_clk};
      // Settled level moves only once two stages agree
      if (alt_sync[1] == alt_sync[2]) begin
        alt_prev <= alt_sync[2];
      end
      if (ev_sync[1] == ev_sync[2]) begin
        ev_prev <= ev_sync[2];
      end
    end
  end

  // Low-then-high on the step bit makes one alt clock edge
  // A rise is taken only when the settled level changes, so a one-cycle glitch is ignored
  assign alt_tick = (alt_sync[1] == alt_sync[2]) && alt_sync[2] && !alt_prev; // R13
  assign ev_tick = (ev_sync[1] == ev_sync[2]) && ev_sync[2] && !ev_prev;
  // Free-running alternate path; with no second clock it is modelled as one count per cycle.
  // It is off whenever the active-low select is high, which covers the select-high, step-bit-high
  // case; stepping is then the only way the alternate clock reaches the counter.
  assign alt_free = !link.alt_clock_enable_n; // R15
  // Alt path runs only when the select pin enables it; stepping bypasses the gate
  // Event clock pulses pass only once the prescaler has opened the path
  assign count_pulse = alt_tick | alt_free | (ev_tick & event_path_enable); // R15

  // Each step access produces one system clock pulse, unless main source is running
  // The address is compared in full so a stray access elsewhere cannot step the clock;
  // the pulse is registered, so it stands for exactly one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_clk_pulse <= 1'b0;
    end else begin
      sys_clk_pulse <= link.step_access && (link.step_addr == edc_pkg::STEP_ADDR)
        && link.clock_source_select; // R12 R14
    end
  end

  // Byte writes into the input latch and control registers
  // Bytes 0 to 4 land in the latch; the top five bits of byte 4 are kept but never loaded.
  // Writing the latch does not touch the counter: only a counting edge with the strobe high does.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Latch starts at the same value as the counter
      latch_wide <= 40'h00_0000_FFFF; // R21
      trig_reg <= 8'h00;
      prescale_reg <= 8'h00;
    end else if (link.wr) begin
      case (link.addr)
        edc_pkg::ADDR_TRIG: begin
          trig_reg <= link.wdata;
        end
        edc_pkg::ADDR_PRESCALE: begin
          prescale_reg <= link.wdata;
        end
        edc_pkg::ADDR_TC: begin
          // Read-only position
        end
        default: begin
          latch_wide[link.addr*8 +: 8] <= link.wdata; // R2
        end
      endcase
    end
  end
  assign input_latch = latch_wide[edc_pkg::CNT_W-1:0];

  // Only the exact free-run code holds the trigger asserted; any other code releases it
  assign trigger_free_run = (trig_reg == edc_pkg::TRIG_FREE_RUN); // R16
  // The event path stays shut until the prescaler holds its opening code, so stray event
  // clock edges before setup cannot disturb the counter
  assign event_path_enable = (prescale_reg == edc_pkg::PRESCALE_INIT); // R17

  // Prescaler sub-counter: loaded to max, first event pulse asserts its tc
  // A prescaler write of the opening code reloads the sub-counter even if an event edge lands in the same cycle;
  // that edge is lost, which only matters while the path is being set up.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_count <= 4'h0;
      sub_tc <= 1'b0;
    end else if (link.wr && link.addr == edc_pkg::ADDR_PRESCALE && link.wdata == edc_pkg::PRESCALE_INIT) begin
      sub_count <= edc_pkg::SUB_MAX; // R17
      sub_tc <= 1'b0;
    end else if (ev_tick && event_path_enable) begin
      // Count events; tc marks the first one after the reload
      sub_count <= sub_count - 4'h1;
      sub_tc <= (sub_count == edc_pkg::SUB_MAX); // R17
    end
  end

  // Counter: load when strobe high, else decrement each pulse
  // The borrow ripples through all 35 bits in one subtraction, so every stage is exercised
  // by a single step from a walking one. Terminal count is a register updated on the same
  // edge as the count, so it never disagrees with the count seen beside it.
  // Counting on from zero wraps to all ones; the user must reload before that matters.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // The counter and its last load start at the reset value, with a low terminal count
      count <= edc_pkg::CNT_RESET; // R10 R21
      last_load <= edc_pkg::CNT_RESET;
      terminal_count <= 1'b0; // R10
    end else if (count_pulse) begin
      // Nothing moves between counting edges
      if (link.load_strobe) begin // R11
        // Copy the latch in and remember it for readback at zero
        count <= input_latch; // R1 R7
        last_load <= input_latch;
        terminal_count <= (input_latch == '0); // R19 R20
      end else begin
        // Count down; terminal count rises as the count leaves one
        count <= count - 35'h0_0000_0001; // R8
        terminal_count <= (count == 35'h0_0000_0001); // R9 R20
      end
    end
  end

  // Readback: inverse of count, or of last load once counted down to zero
  // A zero count therefore reads as the inverse of zero only when zero was loaded: a
  // counted-down zero shows the inverse of the last load instead. Software must not take
  // that readback as proof that nothing was counted.
  always_comb begin
    read_wide = 40'h00_0000_0000;
    if (count == '0) begin
      read_wide[edc_pkg::CNT_W-1:0] = ~last_load; // R5 R6
    end else begin
      read_wide[edc_pkg::CNT_W-1:0] = ~count; // R4
    end
  end

  // Registered read data byte
  // The byte stands from the edge after the read strobe until the next read; the far end
  // must take it no sooner than two cycles after it raised the strobe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.rdata <= 8'h00;
    end else if (link.rd) begin
      if (link.addr == edc_pkg::ADDR_TC) begin
        link.rdata <= {7'h00, terminal_count}; // R9
      end else if (link.addr < edc_pkg::ADDR_TC) begin
        // Counter bytes, low byte at address zero
        link.rdata <= read_wide[link.addr*8 +: 8];
      end else begin
        link.rdata <= 8'h00;
      end
    end
  end
endmodule

//--- src/edc_host.sv
// Processor end: AHB-Lite slave driving byte accesses and clock controls to the counter
`timescale 1ns/100ps
module edc_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  edc_if.host link
);
  typedef enum logic [3:0] {
    EDC_IDLE = 4'b0001,
    EDC_WR = 4'b0010,
    EDC_RD = 4'b0100,
    EDC_WAIT = 4'b1000
  } edc_state_t;

  edc_state_t state; // Sequencer state
  logic [31:0] ctrl; // Control register
  logic [39:0] wr_val; // Value to write
  logic [39:0] rd_val; // Assembled readback
  logic [2:0] idx; // Byte index
  logic ph_valid; // Data phase pending
  logic ph_write; // Pending is a write
  logic [31:0] ph_addr; // Pending address
  logic busy; // Sequence running
  logic [31:0] cmd; // Last command
  logic [2:0] mism; // Upper, middle, lower mismatch flags
  logic [34:0] expect_val; // Last written value; the readback should be its inverse

  assign hresp = 1'b0;
  assign hreadyout = 1'b1;
  assign busy = (state != EDC_IDLE);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 32'h0000_0000;
    end else begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr;
    end
  end

  // Register writes: ctrl bits drive clock controls and load strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= 32'h0000_000E; // Main off, alt off, step bit high
      wr_val <= 40'h00_0000_0000;
      expect_val <= 35'h0_0000_0000;
    end else if (ph_valid && ph_write) begin
      case (ph_addr[7:0])
        edc_pkg::OFS_CTRL[7:0]: begin
          ctrl <= hwdata;
        end
        edc_pkg::OFS_DATA_LO[7:0]: begin
          wr_val[31:0] <= hwdata;
        end
        edc_pkg::OFS_DATA_HI[7:0]: begin
          wr_val[39:32] <= {5'h00, hwdata[2:0]};
          expect_val <= {hwdata[2:0], wr_val[31:0]}; // R18
        end
        default: begin
        end
      endcase
    end
  end

  assign link.load_strobe = ctrl[0]; // R11
  assign link.clock_source_select = ctrl[1]; // R14
  assign link.alt_clock_enable_n = ctrl[2]; // R15
  assign link.alt_clock_step_bit = ctrl[3]; // R13
  assign link.event_clk = ctrl[4];
  assign link.step_addr = edc_pkg::STEP_ADDR;

  // Byte sequencer: five writes or five reads, low byte first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= EDC_IDLE;
      idx <= 3'h0;
      cmd <= 32'h0000_0000;
      rd_val <= 40'h00_0000_0000;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      link.addr <= 3'h0;
      link.wdata <= 8'h00;
      link.step_access <= 1'b0;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      link.step_access <= 1'b0;
      case (state)
        EDC_IDLE: begin
          if (ph_valid && ph_write && ph_addr[7:0] == edc_pkg::OFS_CMD[7:0]) begin
            cmd <= hwdata;
            idx <= 3'h0;
            if (hwdata[1:0] == 2'h1) begin
              state <= EDC_WR;
            end else if (hwdata[1:0] == 2'h2) begin
              state <= EDC_RD;
            end else if (hwdata[1:0] == 2'h3) begin
              link.step_access <= 1'b1;
            end else begin
              link.wr <= hwdata[31];
              link.addr <= hwdata[10:8];
              link.wdata <= hwdata[23:16];
            end
          end
        end
        EDC_WR: begin
          link.wr <= 1'b1;
          link.addr <= idx;
          link.wdata <= wr_val[idx*8 +: 8]; // R2
          idx <= idx + 3'h1;
          if (idx == 3'h4) begin
            state <= EDC_IDLE;
          end
        end
        EDC_RD: begin
          // The byte asked for two cycles ago has settled on rdata by now
          if (idx != 3'h0) begin
            rd_val[(idx-3'h1)*8 +: 8] <= link.rdata; // R3
          end
          if (idx < 3'h5) begin
            link.rd <= 1'b1;
            link.addr <= idx;
            state <= EDC_WAIT;
          end else begin
            state <= EDC_IDLE;
          end
        end
        EDC_WAIT: begin
          // Device registers the byte on this edge
          idx <= idx + 3'h1;
          state <= EDC_RD;
        end
        default: begin
          state <= EDC_IDLE;
        end
      endcase
    end
  end

  // Mismatch split: upper three, middle 16, lower 16
  // A fresh load reads back inverted, so the readback is held against the inverse of the write
  always_comb begin
    mism[2] = rd_val[34:32] != ~expect_val[34:32]; // R18
    mism[1] = rd_val[31:16] != ~expect_val[31:16]; // R18
    mism[0] = rd_val[15:0] != ~expect_val[15:0]; // R18
  end

  // Read data; no slot carries the tc byte, the sequencer reads only bytes 0 to 4
  always_comb begin
    hrdata = 32'h0000_0000;
    case (ph_addr[7:0])
      edc_pkg::OFS_CTRL[7:0]: hrdata = ctrl;
      edc_pkg::OFS_DATA_LO[7:0]: hrdata = rd_val[31:0];
      edc_pkg::OFS_DATA_HI[7:0]: hrdata = {29'h0000_0000, rd_val[34:32]}; // R3
      edc_pkg::OFS_STATUS[7:0]: hrdata = {28'h000_0000, mism, busy}; // R18
      edc_pkg::OFS_CMD[7:0]: hrdata = cmd;
      default: hrdata = 32'h0000_0000;
    endcase
  end
endmodule

//--- sim/edc_asserts.sv
// Checker watching the link and the counter end outputs
`timescale 1ns/100ps
module edc_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic step_access,
  input wire logic [15:0] step_addr,
  input wire logic load_strobe,
  input wire logic clock_source_select,
  input wire logic terminal_count,
  input wire logic trigger_free_run,
  input wire logic event_path_enable,
  input wire logic sys_clk_pulse,
  input wire logic [edc_pkg::CNT_W-1:0] count
);
  logic [edc_pkg::CNT_W-1:0] cnt_q; // Count one cycle back
  logic [7:0] exp_rd; // Inverted byte due on rdata
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Helpers reset with the design so the first edges compare like with like
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= edc_pkg::CNT_RESET;
      exp_rd <= 8'h00;
    end else begin
      cnt_q <= count;
      exp_rd <= 8'((~count) >> (8 * addr));
    end
  end
  // Step request and a count change with the load held off long enough
  sequence step_req;
    step_access && step_addr == edc_pkg::STEP_ADDR && clock_source_select;
  endsequence
  sequence quiet_change;
    (!load_strobe)[*6] ##0 (count != cnt_q);
  endsequence
  reset_state_a: assert property ($rose(hresetn) |-> count == edc_pkg::CNT_RESET && !terminal_count)
    else $error("counter not in its initial state after reset");
  tc_zero_a: assert property (terminal_count == (count == '0))
    else $error("terminal count disagrees with a zero count");
  count_step_a: assert property (quiet_change |-> count == cnt_q - 35'h1)
    else $error("count moved by other than one with load low");
  read_inv_a: assert property (rd && addr < 3'h5 && count != '0 |=> rdata == exp_rd)
    else $error("read byte is not the inverted count");
  step_pulse_a: assert property (step_req |=> sys_clk_pulse)
    else $error("step access gave no clock pulse");
  pulse_cause_a: assert property (sys_clk_pulse |-> $past(step_access) && $past(clock_source_select))
    else $error("clock pulse without a step access");
  pulse_single_a: assert property (sys_clk_pulse |=> !sys_clk_pulse)
    else $error("clock pulse longer than one cycle");
  trig_on_a: assert property (wr && addr == edc_pkg::ADDR_TRIG && wdata == edc_pkg::TRIG_FREE_RUN
    |=> trigger_free_run)
    else $error("trigger not in free run");
  trig_off_a: assert property (wr && addr == edc_pkg::ADDR_TRIG && wdata != edc_pkg::TRIG_FREE_RUN
    |=> !trigger_free_run)
    else $error("trigger free run without its code");
  prescale_a: assert property (wr && addr == edc_pkg::ADDR_PRESCALE && wdata == edc_pkg::PRESCALE_INIT
    |=> event_path_enable)
    else $error("event path not enabled");
endmodule

//--- sim/tb_event_delay_down_counter.sv
// Testbench driving the processor end over AHB-Lite against the counter end
`timescale 1ns/100ps
module tb_event_delay_down_counter;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, ctrl, st;
  logic hreadyout, hresp, terminal_count, trigger_free_run, event_path_enable, sub_tc, sys_clk_pulse;
  logic [34:0] count, cv, pat;
  int errors = 0;
  int tests_run = 0;
  int pulses = 0; // Clock pulses seen on the counter end
  int p0;
  edc_if lnk();
  edc_host edc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .link(lnk));
  edc_counter edc_counter_inst (.hclk(hclk), .hresetn(hresetn), .link(lnk), .terminal_count(terminal_count),
    .trigger_free_run(trigger_free_run), .event_path_enable(event_path_enable), .sub_tc(sub_tc),
    .sys_clk_pulse(sys_clk_pulse), .count(count));
  edc_asserts edc_asserts_inst (.hclk(hclk), .hresetn(hresetn), .wr(lnk.wr), .rd(lnk.rd), .addr(lnk.addr),
    .wdata(lnk.wdata), .rdata(lnk.rdata), .step_access(lnk.step_access), .step_addr(lnk.step_addr),
    .load_strobe(lnk.load_strobe), .clock_source_select(lnk.clock_source_select),
    .terminal_count(terminal_count), .trigger_free_run(trigger_free_run),
    .event_path_enable(event_path_enable), .sys_clk_pulse(sys_clk_pulse), .count(count));
  // Clock at 250 MHz
  always #2 hclk = ~hclk;
  // Tally clock pulses; one-cycle pulses are caught on every edge
  always @(posedge hclk) if (sys_clk_pulse === 1'b1) pulses++;
  // One single transfer; address held until hready, data held until hready again
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  // Issue a command and poll busy; a bounded poll, the watchdog covers the rest
  task automatic cmd(input logic [31:0] c);
    logic [31:0] s;
    int n;
    n = 0;
    wr32(edc_pkg::OFS_CMD, c);
    do begin
      bus(1'b0, edc_pkg::OFS_STATUS, 32'h0000_0000, s);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    chk_f("busy clear", 1'b0, s[0]);
  endtask
  // Rising edge on one control bit; the edge lands after a few synchroniser flops
  task automatic tick(input int b);
    wr32(edc_pkg::OFS_CTRL, ctrl & ~(32'h0000_0001 << b));
    wr32(edc_pkg::OFS_CTRL, ctrl | (32'h0000_0001 << b));
    wr32(edc_pkg::OFS_CTRL, ctrl);
    repeat (8) @(posedge hclk);
  endtask
  // Write the latches low byte first, then clock them in with the load high
  task automatic load(input logic [34:0] v, input int b);
    wr32(edc_pkg::OFS_DATA_LO, v[31:0]);
    wr32(edc_pkg::OFS_DATA_HI, {29'h0000_0000, v[34:32]});
    cmd(32'h0000_0001);
    ctrl[0] = 1'b1;
    tick(b);
    ctrl[0] = 1'b0;
    wr32(edc_pkg::OFS_CTRL, ctrl);
  endtask
  task automatic rdc(output logic [34:0] v);
    logic [31:0] lo, hi;
    cmd(32'h0000_0002);
    bus(1'b0, edc_pkg::OFS_DATA_LO, 32'h0000_0000, lo);
    bus(1'b0, edc_pkg::OFS_DATA_HI, 32'h0000_0000, hi);
    v = {hi[2:0], lo};
  endtask
  task automatic chk_v(input string n, input logic [34:0] e, input logic [34:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_f(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  // Counts, verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    ctrl = 32'h0000_000E; // Main clock off, alternate clock idle high
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_v("reset count", edc_pkg::CNT_RESET, count);
    chk_f("reset tc", 1'b0, terminal_count);
    $display("test reset done");
    // Setup first: the event clock reaches the counter only once the prescaler opens the path
    cmd(32'h8003_0600);
    chk_f("free run on", 1'b1, trigger_free_run);
    cmd(32'h8004_0600);
    chk_f("free run off", 1'b0, trigger_free_run);
    cmd(32'h80F2_0700);
    chk_f("event path", 1'b1, event_path_enable);
    tick(4); // First event pulse after the prescaler reload, load strobe low
    chk_f("sub tc first pulse", 1'b1, sub_tc);
    chk_v("count after first event", edc_pkg::CNT_RESET - 35'h1, count);
    $display("test setup registers done");
    // Walking one down every bit, each followed by one decrement
    for (int i = 34; i >= 0; i--) begin
      pat = 35'h1 << i;
      load(pat, 4);
      chk_v("loaded count", pat, count);
      chk_f("tc after load", 1'b0, terminal_count);
      rdc(cv);
      chk_v("readback after load", ~pat, cv);
      bus(1'b0, edc_pkg::OFS_STATUS, 32'h0000_0000, st);
      chk_v("mismatch flags after load", 35'h0, 35'(st[3:1]));
      tick(4);
      chk_v("stepped count", pat - 35'h1, count);
      chk_f("tc after step", pat == 35'h1, terminal_count);
      rdc(cv);
      chk_v("readback after step", (pat == 35'h1) ? ~pat : ~(pat - 35'h1), cv);
    end
    $display("test walking ones done");
    load(35'h0, 3); // Clocked by the alternate clock bit, low then high
    chk_f("tc zero load", 1'b1, terminal_count);
    rdc(cv);
    chk_v("readback zero load", 35'h7_FFFF_FFFF, cv);
    bus(1'b0, edc_pkg::OFS_STATUS, 32'h0000_0000, st);
    chk_v("mismatch flags zero load", 35'h0, 35'(st[3:1]));
    $display("test load zero done");
    p0 = pulses;
    cmd(32'h0000_0003);
    @(posedge hclk); // Let the pulse tally settle before looking
    chk_v("pulses stepped", 35'h1, 35'(pulses - p0));
    ctrl[1] = 1'b0; // Main clock source running: stepping must not pulse
    wr32(edc_pkg::OFS_CTRL, ctrl);
    cmd(32'h0000_0003);
    @(posedge hclk); // Let the pulse tally settle before looking
    chk_v("pulses free clock", 35'h1, 35'(pulses - p0));
    ctrl[1] = 1'b1;
    wr32(edc_pkg::OFS_CTRL, ctrl);
    $display("test clock step done");
    test_done();
  end
  // Watchdog: the whole run needs well under 50000 cycles
  initial begin
    #(4 * 50000);
    errors++;
    test_done();
  end
endmodule
